// *** hdl/fle8_entry.sv ***
// What this block does
// - in low resolution threshold mode the top threshold bit ignores writes and reads zero.
// - in high resolution threshold mode the top bit joins the low seven bits to form the threshold.
// - the threshold spans 0 to 127.5 degrees in half steps (high res) or 0 to 127 in whole steps (low res).
// - when remote temperature is strictly above the threshold entryActive is set at the next clock; entryDuty carries the duty whatever the compare.
// - the compare uses nine reading bits in high resolution and eight in low resolution.
// - thresholds are always non-negative, sign bit taken as zero.
// - the table temperature offset is added to the programmed threshold.
// - in low resolution duty mode the two top duty bits are unused and read zero.
// - in high resolution duty mode the two top bits join the low six bits into an eight-bit duty.
// - the duty extension bits act only when the fast pwm frequency is selected.
// - in low resolution duty mode the low six bits alone give the duty, reset value all ones.
// Purpose: lookup table entry eight, threshold and duty registers with compare
// Assumes: remoteTemp is unsigned, half-degree lsb at bit 0, bit 9 never compared
// Assumes: offset in whole degrees
// Notes: read data registered one cycle after rdEn
`timescale 1ns/1ps
`include "fle8_regs.svh"
module fle8_entry (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire fle8_pkg::fle8_hostreq_t hostReq,
  input wire fle8_pkg::fle8_mode_t mode,
  input wire logic [7:0] tableTempOffset,
  input wire logic [9:0] remoteTemp,
  output logic [7:0] rdData,
  output logic entryActive,
  output logic [7:0] entryDuty
);
  import fle8_pkg::*;

  // ---------------------------------------
  // host address decode
  // ---------------------------------------
  logic hitThr;
  logic hitDuty;
  logic hitAny;

  assign hitThr = (hostReq.addr == `FLE8_ADDR_THRESHOLD);
  assign hitDuty = (hostReq.addr == `FLE8_ADDR_DUTY);
  assign hitAny = hitThr | hitDuty;

  // ---------------------------------------
  // write qualify
  // ---------------------------------------
  logic wrAllowed;
  logic wrThr;
  logic wrDuty;

  assign wrAllowed = hostReq.wrEn & mode.tableWriteEnable;
  assign wrThr = wrAllowed & hitThr;
  assign wrDuty = wrAllowed & hitDuty;

  // ---------------------------------------
  // threshold write fields
  // ---------------------------------------
  logic wrThrTop;
  logic [6:0] wrThrLow;
  logic [7:0] next_threshold;

  assign wrThrTop = hostReq.wrData[`FLE8_THR_TOP] & mode.thrHighRes;
  assign wrThrLow = hostReq.wrData[`FLE8_THR_LOW_HI:`FLE8_FIELD_LO];
  assign next_threshold = {wrThrTop, wrThrLow};

  // ---------------------------------------
  // threshold storage
  // ---------------------------------------
  logic [7:0] thresholdReg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      thresholdReg <= `FLE8_RST_THRESHOLD;
    end else if (wrThr) begin
      thresholdReg <= next_threshold;
    end
  end

  // ---------------------------------------
  // duty write fields
  // ---------------------------------------
  logic [1:0] wrDutyExt;
  logic [5:0] wrDutyBase;
  logic [7:0] next_duty;

  assign wrDutyExt = hostReq.wrData[`FLE8_DUTY_EXT_HI:`FLE8_DUTY_EXT_LO];
  assign wrDutyBase = hostReq.wrData[`FLE8_DUTY_BASE_HI:`FLE8_FIELD_LO];
  assign next_duty = {wrDutyExt, wrDutyBase};

  // ---------------------------------------
  // duty storage
  // ---------------------------------------
  logic [7:0] dutyReg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dutyReg <= `FLE8_RST_DUTY;
    end else if (wrDuty) begin
      dutyReg <= next_duty;
    end
  end

  // ---------------------------------------
  // stored fields
  // ---------------------------------------
  logic thresholdTopBit;
  logic [6:0] thresholdLowBits;
  logic [1:0] dutyExtensionBits;
  logic [5:0] dutyBaseBits;

  assign thresholdTopBit = thresholdReg[`FLE8_THR_TOP] & mode.thrHighRes;
  assign thresholdLowBits = thresholdReg[`FLE8_THR_LOW_HI:`FLE8_FIELD_LO];
  assign dutyExtensionBits = dutyReg[`FLE8_DUTY_EXT_HI:`FLE8_DUTY_EXT_LO];
  assign dutyBaseBits = dutyReg[`FLE8_DUTY_BASE_HI:`FLE8_FIELD_LO];

  // ---------------------------------------
  // read views
  // ---------------------------------------
  logic [7:0] thresholdView;
  logic [1:0] dutyViewExt;
  logic [7:0] dutyView;

  assign thresholdView = {thresholdTopBit, thresholdLowBits};
  assign dutyViewExt = mode.dutyHighRes ? dutyExtensionBits : `FLE8_ZERO2;
  assign dutyView = {dutyViewExt, dutyBaseBits};

  // ---------------------------------------
  // read select
  // ---------------------------------------
  logic [7:0] mappedData;
  logic [7:0] next_rdData;

  assign mappedData = hitThr ? thresholdView : dutyView;
  assign next_rdData = hitAny ? mappedData : `FLE8_RD_IDLE;

  // ---------------------------------------
  // read data register
  // ---------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData <= `FLE8_RD_IDLE;
    end else if (hostReq.rdEn) begin
      rdData <= next_rdData;
    end
  end

  // ---------------------------------------
  // threshold in half degrees
  // ---------------------------------------
  logic [8:0] thrHalfHigh;
  logic [8:0] thrHalfLow;
  logic [8:0] thrHalf;

  assign thrHalfHigh = {`FLE8_ZERO1, thresholdView};
  assign thrHalfLow = {`FLE8_ZERO1, thresholdLowBits, `FLE8_ZERO1};
  assign thrHalf = mode.thrHighRes ? thrHalfHigh : thrHalfLow;

  // ---------------------------------------
  // table offset
  // ---------------------------------------
  logic [9:0] offsetHalf;
  logic [9:0] thrTotal;

  assign offsetHalf = {`FLE8_ZERO1, tableTempOffset, `FLE8_ZERO1};
  assign thrTotal = {`FLE8_ZERO1, thrHalf} + offsetHalf;

  // ---------------------------------------
  // reading select
  // ---------------------------------------
  logic [8:0] tempHigh;
  logic [7:0] tempWhole;
  logic [9:0] tempHighExt;
  logic [9:0] tempLowExt;
  logic [9:0] tempUsed;

  assign tempHigh = remoteTemp[`FLE8_TEMP_HI:`FLE8_FIELD_LO];
  assign tempWhole = remoteTemp[`FLE8_TEMP_HI:`FLE8_TEMP_WHOLE_LO];
  assign tempHighExt = {`FLE8_ZERO1, tempHigh};
  assign tempLowExt = {`FLE8_ZERO1, tempWhole, `FLE8_ZERO1};
  assign tempUsed = mode.thrHighRes ? tempHighExt : tempLowExt;

  // ---------------------------------------
  // compare
  // ---------------------------------------
  logic next_entryActive;

  assign next_entryActive = (tempUsed > thrTotal);

  // ---------------------------------------
  // duty select
  // ---------------------------------------
  logic extUsable;
  logic [1:0] activeExt;
  logic [7:0] next_entryDuty;

  assign extUsable = mode.dutyHighRes & mode.pwmFreqFast;
  assign activeExt = extUsable ? dutyExtensionBits : `FLE8_ZERO2;
  assign next_entryDuty = {activeExt, dutyBaseBits};

  // ---------------------------------------
  // compare result register
  // ---------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      entryActive <= `FLE8_ZERO1;
    end else begin
      entryActive <= next_entryActive;
    end
  end

  // ---------------------------------------
  // duty output register
  // ---------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      entryDuty <= `FLE8_RST_DUTY;
    end else begin
      entryDuty <= next_entryDuty;
    end
  end
endmodule : fle8_entry

// *** hdl/fle8_pkg.sv ***
// Purpose: types for lookup entry eight
// Assumes: none
// Notes: host access travels as one struct
package fle8_pkg;
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } fle8_hostreq_t;
  typedef struct packed {
    logic thrHighRes;
    logic dutyHighRes;
    logic pwmFreqFast;
    logic tableWriteEnable;
  } fle8_mode_t;
endpackage : fle8_pkg

// *** hdl/fle8_regs.svh ***
// Purpose: offsets, reset values and field positions for lookup entry eight
// Assumes: byte-wide host register port
// Notes: definitions only
`ifndef FLE8_REGS_SVH
`define FLE8_REGS_SVH
`define FLE8_ADDR_THRESHOLD 8'h5e
`define FLE8_ADDR_DUTY 8'h5f
`define FLE8_RST_THRESHOLD 8'h7f
`define FLE8_RST_DUTY 8'h3f
`define FLE8_THR_TOP 7
`define FLE8_DUTY_EXT_HI 7
`define FLE8_DUTY_EXT_LO 6
`define FLE8_ZERO2 2'h0
`define FLE8_ZERO1 1'h0
`define FLE8_THR_LOW_HI 6
`define FLE8_DUTY_BASE_HI 5
`define FLE8_FIELD_LO 0
`define FLE8_TEMP_HI 8
`define FLE8_TEMP_WHOLE_LO 1
`define FLE8_RD_IDLE 8'h00
`endif

// *** test/fle8_checker.sv ***
// Purpose: entry eight port checks; Assumes: one cycle lag; Notes: bound at foot
`timescale 1ns/1ps
module fle8_checker (input wire logic sys_clk, input wire logic sys_rst, input wire fle8_pkg::fle8_hostreq_t hostReq,
  input wire fle8_pkg::fle8_mode_t mode, input wire logic [7:0] tableTempOffset, input wire logic [9:0] remoteTemp,
  input wire logic [7:0] rdData, input wire logic entryActive, input wire logic [7:0] entryDuty);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire rT = hostReq.rdEn && !hostReq.wrEn && hostReq.addr == 8'h5e;
  wire rD = hostReq.rdEn && !hostReq.wrEn && hostReq.addr == 8'h5f;
  sequence sWr; hostReq.wrEn && mode.tableWriteEnable && hostReq.addr == 8'h5e && mode.thrHighRes; endsequence
  AST_WRRD: assert property (sWr ##2 (rT && mode.thrHighRes) |=> rdData == $past(hostReq.wrData, 3))
    else $error("bad readback");
  AST_LOWTOP: assert property (rT && !mode.thrHighRes |=> !rdData[7]) else $error("top bit set");
  AST_DUTYTOP: assert property (rD && !mode.dutyHighRes |=> rdData[7:6] == 2'h0) else $error("duty top set");
  AST_EXT: assert property (!mode.pwmFreqFast |=> entryDuty[7:6] == 2'h0) else $error("ext active");
  AST_UNMAP: assert property (hostReq.rdEn && hostReq.addr[7:1] != 7'h2f |=> rdData == 8'h00) else $error("unmap");
  AST_HOLD: assert property (!hostReq.rdEn |=> $stable(rdData)) else $error("read data moved");
  AST_HOT: assert property (remoteTemp == 10'h3ff && tableTempOffset == 8'h00 |=> entryActive) else $error("hot");
  AST_COLD: assert property (remoteTemp == 10'h000 |=> !entryActive) else $error("cold");
endmodule : fle8_checker
bind fle8_entry fle8_checker u_chk (.*);

// *** test/fle8_entry_tb.sv ***
// Purpose: entry eight bench; Assumes: read data one cycle after strobe; Notes: fixed stimulus
`timescale 1ns/1ps
module fle8_entry_tb;
  import fle8_pkg::*;
  logic sys_clk = 0, sys_rst = 1, act;
  fle8_hostreq_t hostReq = '0;
  fle8_mode_t mode = '0;
  logic [7:0] off = 8'h00, rdData, duty;
  logic [9:0] temp = 10'h000;
  int fails = 0, n_checks = 0;
  fle8_entry u_dut (.sys_clk, .sys_rst, .hostReq, .mode, .tableTempOffset(off), .remoteTemp(temp), .rdData,
    .entryActive(act), .entryDuty(duty));
  initial forever #12.5 sys_clk = ~sys_clk;
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin fails++; $display("MISMATCH %0t got %h want %h", $time, g, e); end
  endtask : chk
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge sys_clk) hostReq <= {w, !w, a, d};
    @(posedge sys_clk) hostReq <= '0;
    #1 if (!w) chk(rdData, e);
  endtask : acc
  task close_out;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin #4000 fails++; close_out; end
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 0;
    acc(0, 8'h5e, 0, 8'h7f); acc(0, 8'h5f, 0, 8'h3f);
    acc(1, 8'h5e, 8'h12, 0); acc(0, 8'h5e, 0, 8'h7f);
    mode <= 4'hf; acc(1, 8'h5e, 8'ha5, 0); acc(0, 8'h5e, 0, 8'ha5);
    acc(1, 8'h5f, 8'hc7, 0); acc(0, 8'h5f, 0, 8'hc7); chk(duty, 8'hc7);
    mode <= 4'h5; acc(0, 8'h60, 0, 0); chk(duty, 8'h07);
    mode <= 4'h1; acc(0, 8'h5f, 0, 8'h07);
    acc(1, 8'h5e, 8'hc4, 0); acc(0, 8'h5e, 0, 8'h44);
    $display("register test done");
    off <= 8'h02; temp <= 10'h08d; acc(0, 8'h60, 0, 0); chk({7'h0, act}, 8'h00);
    temp <= 10'h08e; acc(0, 8'h60, 0, 0); chk({7'h0, act}, 8'h01);
    off <= 8'h00; temp <= 10'h3ff; acc(0, 8'h60, 0, 0); chk({7'h0, act}, 8'h01);
    temp <= 10'h000; acc(0, 8'h60, 0, 0); chk({7'h0, act}, 8'h00);
    mode <= 4'hf; acc(1, 8'h5e, 8'ha5, 0); acc(0, 8'h5e, 0, 8'ha5);
    temp <= 10'h2a5; acc(0, 8'h60, 0, 0); chk({7'h0, act}, 8'h00);
    temp <= 10'h0a6; acc(0, 8'h60, 0, 0); chk({7'h0, act}, 8'h01);
    $display("compare test done");
    close_out;
  end
endmodule : fle8_entry_tb
